/* can_mode_ctrl.sv */
`timescale 1ns/10ps

// Notes on behaviour
// - auto bus-off exit after 128 runs of 11
// - auto wake-up on frame clears sleep bits
// - without auto wake-up, software clears sleep
// - no-retransmit: each message sent once
// - otherwise retransmit until success
// - full unlocked queue: newest overwrites last
// - full locked queue: new message discarded
// - order by identifier or by request time
// - sleep entered after current frame ends
// - leaving init waits 11 recessive bits
// - init entered after current frame ends
// - clearable flags cleared by writing one
// - receiving and transmitting status bits
// - wake-up flag on start-of-frame in sleep
// - error flag on enabled error condition
// - sleep ack follows sleep mode
// - success flag set, cleared by request/clear
// - request done sticky until software clears
// - lowest flags only with two pending
// - reserved bits read zero, except event enable bits 5:4, which read back as written
// - control and status reset to 02h
// - code: next free or lowest pending
// - pending count up on store, down on release
module can_mode_ctrl
    import can_mode_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       SRST_I,
    // register port
    input  wire reg_req_t   REG_I,
    output logic [7:0]      RDATA_O,
    // can receive pin
    input  wire logic       CAN_RX_I,
    // protocol engine status
    input  wire logic       RX_ACTIVE_I,
    input  wire logic       TX_ACTIVE_I,
    input  wire logic       SOF_DET_I,
    input  wire logic [3:0] ERR_SET_I,
    input  wire logic       BUSOFF_ENTER_I,
    input  wire tx_evt_t    TX_EVT_I,
    input  wire logic [1:0] TX_PEND_I,
    input  wire logic       MB0_ID_WINS_I,
    input  wire logic       RX_STORE_I,
    // mode and policy outputs
    output logic            SLEEP_MODE_O,
    output logic            INIT_MODE_O,
    output logic            BUS_ON_O,
    output logic            BUSOFF_RECOVER_O,
    output logic            NO_RETRANSMIT_O,
    output logic            NEXT_TX_MB_O,
    output logic            RX_OVERWRITE_O,
    output logic            RX_DISCARD_O,
    output logic            STATUS_CHANGE_O
);

    // ****************
    // state
    // ****************
    mode_t      mode_reg;
    mode_t      mode_next;
    logic [6:0] control_reg;
    logic       wakeup_event_reg;
    logic       error_event_reg;
    logic [1:0] tx_success_reg;
    logic [1:0] request_done_reg;
    logic       last_req_reg;
    logic [1:0] pending_message_count_reg;
    logic       overrun_reg;
    logic       full_reg;
    logic [7:0] event_enable_reg;
    logic [7:0] rdata_reg;
    logic [2:0] rx_sync_reg;
    logic       rx_level_reg;
    logic [7:0] bit_div_reg;
    logic [7:0] rec_run_reg;
    logic [7:0] busoff_runs_reg;
    logic       recover_reg;
    logic       overwrite_reg;
    logic       discard_reg;

    logic       wr_ctl;
    logic       wr_sts;
    logic       wr_tsr;
    logic       wr_rxq;
    logic       wr_evt;
    logic       busy;
    logic       bit_tick;
    logic       run11;
    logic       auto_wake;
    logic       release_q;
    logic       both_pend;
    logic       lowest_mb;
    logic [1:0] lowest_flags;
    logic [1:0] code;

    assign wr_ctl    = REG_I.wr && (REG_I.addr == OFS_MASTER_CONTROL);
    assign wr_sts    = REG_I.wr && (REG_I.addr == OFS_MASTER_STATUS);
    assign wr_tsr    = REG_I.wr && (REG_I.addr == OFS_TX_STATUS);
    assign wr_rxq    = REG_I.wr && (REG_I.addr == OFS_RX_QUEUE);
    assign wr_evt    = REG_I.wr && (REG_I.addr == OFS_EVENT_ENABLE);
    assign busy      = RX_ACTIVE_I || TX_ACTIVE_I;
    assign auto_wake = (mode_reg == ST_SLEEP) && control_reg[B_AUTO_WAKEUP] && SOF_DET_I;

    // ****************
    // receive pin synchroniser and bit-time divider
    // ****************
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            rx_sync_reg  <= 3'h7;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], CAN_RX_I};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_level_reg <= rx_sync_reg[2];
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            bit_div_reg <= 8'h00;
        end else if (bit_tick) begin
            bit_div_reg <= 8'h00;
        end else begin
            bit_div_reg <= bit_div_reg + 8'h01;
        end
    end

    assign bit_tick = (bit_div_reg == 8'(BIT_CYCLES - 1));
    assign run11    = bit_tick && rx_level_reg && (rec_run_reg == RECESSIVE_RUN - 8'h01);

    // consecutive recessive bits, restarted after each run of 11
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            rec_run_reg <= 8'h00;
        end else if (bit_tick) begin
            if (!rx_level_reg || run11) begin
                rec_run_reg <= 8'h00;
            end else begin
                rec_run_reg <= rec_run_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            busoff_runs_reg <= 8'h00;
        end else if (mode_reg != ST_BUSOFF) begin
            busoff_runs_reg <= 8'h00;
        end else if (run11) begin
            busoff_runs_reg <= busoff_runs_reg + 8'h01;
        end
    end

    // ****************
    // operating mode
    // ****************
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_SLEEP: begin
                if (!control_reg[B_SLEEP_REQ] || auto_wake) begin
                    mode_next = control_reg[B_INIT_REQ] ? ST_INIT : ST_SYNC;
                end
            end
            ST_INIT: begin
                if (control_reg[B_SLEEP_REQ]) begin
                    mode_next = ST_SLEEP;
                end else if (!control_reg[B_INIT_REQ]) begin
                    mode_next = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (control_reg[B_INIT_REQ]) begin
                    mode_next = ST_INIT;
                end else if (control_reg[B_SLEEP_REQ]) begin
                    mode_next = ST_SLEEP;
                end else if (run11) begin
                    mode_next = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (BUSOFF_ENTER_I) begin
                    mode_next = ST_BUSOFF;
                end else if (control_reg[B_INIT_REQ] && !busy) begin
                    mode_next = ST_INIT;
                end else if (control_reg[B_SLEEP_REQ] && !busy) begin
                    mode_next = ST_SLEEP;
                end
            end
            ST_BUSOFF: begin
                if (control_reg[B_AUTO_BUSOFF] && run11
                    && (busoff_runs_reg == BUSOFF_RUNS - 8'h01)) begin
                    mode_next = ST_NORMAL;
                end else if (!control_reg[B_AUTO_BUSOFF] && control_reg[B_INIT_REQ]) begin
                    mode_next = ST_INIT;
                end
            end
            default: begin
                mode_next = ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            mode_reg    <= ST_SLEEP;
            recover_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            recover_reg <= (mode_reg == ST_BUSOFF) && (mode_next != ST_BUSOFF);
        end
    end

    // ****************
    // master control
    // ****************
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            control_reg <= RST_MASTER_CONTROL[6:0];
        end else if (wr_ctl) begin
            control_reg <= REG_I.wdata[6:0];
        end else if (auto_wake) begin
            control_reg[B_SLEEP_REQ] <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            event_enable_reg <= RST_EVENT_ENABLE;
        end else if (wr_evt) begin
            event_enable_reg <= REG_I.wdata;
        end
    end

    // ****************
    // status event flags, set wins over write-one clear
    // ****************
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            wakeup_event_reg <= 1'b0;
            error_event_reg  <= 1'b0;
        end else begin
            if ((mode_reg == ST_SLEEP) && SOF_DET_I) begin
                wakeup_event_reg <= 1'b1;
            end else if (wr_sts && REG_I.wdata[B_WAKEUP_EVT]) begin
                wakeup_event_reg <= 1'b0;
            end
            if (|(ERR_SET_I & event_enable_reg[B_COND_EN +: 4])) begin
                error_event_reg <= 1'b1;
            end else if (wr_sts && REG_I.wdata[B_ERROR_EVT]) begin
                error_event_reg <= 1'b0;
            end
        end
    end

    // ****************
    // transmit mailbox flags
    // ****************
    generate
        for (genvar mb = 0; mb < 2; mb++) begin : g_mb
            always_ff @(posedge SYS_CLK_I) begin
                if (SRST_I) begin
                    tx_success_reg[mb]   <= 1'b0;
                    request_done_reg[mb] <= 1'b0;
                end else begin
                    if (TX_EVT_I.done[mb]) begin
                        request_done_reg[mb] <= 1'b1;
                    end else if (wr_tsr && REG_I.wdata[B_REQ_DONE + mb]) begin
                        request_done_reg[mb] <= 1'b0;
                    end
                    if (TX_EVT_I.ok[mb]) begin
                        tx_success_reg[mb] <= 1'b1;
                    end else if (TX_EVT_I.req[mb]
                                 || (wr_tsr && REG_I.wdata[B_REQ_DONE + mb])) begin
                        tx_success_reg[mb] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // the later of two requests is the one that waits
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            last_req_reg <= 1'b0;
        end else if (TX_EVT_I.req[1]) begin
            last_req_reg <= 1'b1;
        end else if (TX_EVT_I.req[0]) begin
            last_req_reg <= 1'b0;
        end
    end

    assign both_pend    = &TX_PEND_I;
    assign lowest_mb    = control_reg[B_TX_ORDER] ? last_req_reg : MB0_ID_WINS_I;
    assign lowest_flags = both_pend ? (lowest_mb ? 2'h2 : 2'h1) : 2'h0;
    assign code         = !TX_PEND_I[0] ? 2'h0 :
                          !TX_PEND_I[1] ? 2'h1 : {1'b0, lowest_mb};

    // ****************
    // receive queue occupancy
    // ****************
    assign release_q = wr_rxq && REG_I.wdata[B_RELEASE] && (pending_message_count_reg != 2'h0);

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            pending_message_count_reg <= 2'h0;
            overrun_reg               <= 1'b0;
            full_reg                  <= 1'b0;
            overwrite_reg             <= 1'b0;
            discard_reg               <= 1'b0;
        end else begin
            overwrite_reg <= 1'b0;
            discard_reg   <= 1'b0;
            if (RX_STORE_I && (pending_message_count_reg == QUEUE_DEPTH) && !release_q) begin
                overrun_reg <= 1'b1;
                if (control_reg[B_RX_LOCK]) begin
                    discard_reg <= 1'b1;
                end else begin
                    overwrite_reg <= 1'b1;
                end
            end else if (wr_rxq && REG_I.wdata[B_OVERRUN]) begin
                overrun_reg <= 1'b0;
            end
            if (RX_STORE_I && !release_q && (pending_message_count_reg != QUEUE_DEPTH)) begin
                pending_message_count_reg <= pending_message_count_reg + 2'h1;
            end else if (release_q && !RX_STORE_I) begin
                pending_message_count_reg <= pending_message_count_reg - 2'h1;
            end
            if (RX_STORE_I && !release_q && (pending_message_count_reg == QUEUE_DEPTH - 2'h1)) begin
                full_reg <= 1'b1;
            end else if (release_q || (wr_rxq && REG_I.wdata[B_FULL])) begin
                full_reg <= 1'b0;
            end
        end
    end

    // ****************
    // register read, data one cycle after the strobe
    // ****************
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            rdata_reg <= 8'h00;
        end else if (REG_I.rd) begin
            case (REG_I.addr)
                OFS_MASTER_CONTROL: begin
                    rdata_reg <= {1'b0, control_reg};
                end
                OFS_MASTER_STATUS: begin
                    rdata_reg <= {2'b00, RX_ACTIVE_I, TX_ACTIVE_I,
                                  wakeup_event_reg, error_event_reg,
                                  mode_reg == ST_SLEEP, mode_reg == ST_INIT};
                end
                OFS_TX_STATUS: begin
                    rdata_reg <= {2'b00, tx_success_reg, 2'b00, request_done_reg};
                end
                OFS_TX_PRIORITY: begin
                    rdata_reg <= {1'b0, lowest_flags, 1'b0, ~TX_PEND_I, code};
                end
                OFS_RX_QUEUE: begin
                    rdata_reg <= {3'b000, overrun_reg, full_reg, 1'b0,
                                  pending_message_count_reg};
                end
                OFS_EVENT_ENABLE: begin
                    rdata_reg <= event_enable_reg;
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ****************
    // outputs
    // ****************
    assign RDATA_O          = rdata_reg;
    assign SLEEP_MODE_O     = (mode_reg == ST_SLEEP);
    assign INIT_MODE_O      = (mode_reg == ST_INIT);
    assign BUS_ON_O         = (mode_reg == ST_NORMAL);
    assign BUSOFF_RECOVER_O = recover_reg;
    assign NO_RETRANSMIT_O  = control_reg[B_NO_RETRANSMIT];
    assign NEXT_TX_MB_O     = both_pend ? ~lowest_mb : TX_PEND_I[1];
    assign RX_OVERWRITE_O   = overwrite_reg;
    assign RX_DISCARD_O     = discard_reg;
    assign STATUS_CHANGE_O  = (wakeup_event_reg && event_enable_reg[B_WAKEUP_IRQ_EN])
                           || (error_event_reg && event_enable_reg[B_ERROR_IRQ_EN]);

endmodule

/* can_mode_pkg.sv */
package can_mode_pkg;

    // ****************
    // register offsets
    // ****************
    localparam logic [7:0] OFS_MASTER_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_MASTER_STATUS   = 8'h01;
    localparam logic [7:0] OFS_TX_STATUS       = 8'h02;
    localparam logic [7:0] OFS_TX_PRIORITY     = 8'h03;
    localparam logic [7:0] OFS_RX_QUEUE        = 8'h04;
    localparam logic [7:0] OFS_EVENT_ENABLE    = 8'h05;

    // ****************
    // reset values
    // ****************
    localparam logic [7:0] RST_MASTER_CONTROL  = 8'h02;
    localparam logic [7:0] RST_MASTER_STATUS   = 8'h02;
    localparam logic [7:0] RST_TX_STATUS       = 8'h00;
    localparam logic [7:0] RST_TX_PRIORITY     = 8'h0C;
    localparam logic [7:0] RST_RX_QUEUE        = 8'h00;
    localparam logic [7:0] RST_EVENT_ENABLE    = 8'h00;

    // ****************
    // field positions
    // ****************
    // master control
    localparam int B_AUTO_BUSOFF   = 6;
    localparam int B_AUTO_WAKEUP   = 5;
    localparam int B_NO_RETRANSMIT = 4;
    localparam int B_RX_LOCK       = 3;
    localparam int B_TX_ORDER      = 2;
    localparam int B_SLEEP_REQ     = 1;
    localparam int B_INIT_REQ      = 0;
    // master status
    localparam int B_RECEIVING     = 5;
    localparam int B_TRANSMITTING  = 4;
    localparam int B_WAKEUP_EVT    = 3;
    localparam int B_ERROR_EVT     = 2;
    localparam int B_SLEEP_ACK     = 1;
    localparam int B_INIT_ACK      = 0;
    // transmit status
    localparam int B_TX_SUCCESS    = 4;
    localparam int B_REQ_DONE      = 0;
    // transmit priority
    localparam int B_LOWEST        = 5;
    localparam int B_MB_FREE       = 2;
    localparam int B_CODE          = 0;
    // receive queue
    localparam int B_RELEASE       = 5;
    localparam int B_OVERRUN       = 4;
    localparam int B_FULL          = 3;
    localparam int B_PENDING       = 0;
    // event enables
    localparam int B_WAKEUP_IRQ_EN = 7;
    localparam int B_ERROR_IRQ_EN  = 6;
    localparam int B_COND_EN       = 0;

    // ****************
    // timing and counts
    // ****************
    localparam int CLK_PERIOD_NS   = 20;
    localparam int BIT_TIME_NS     = 2000;
    localparam int BIT_CYCLES      = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RECESSIVE_RUN   = 8'h0B;
    localparam logic [7:0] BUSOFF_RUNS     = 8'h80;
    localparam logic [1:0] QUEUE_DEPTH     = 2'h3;

    // ****************
    // types
    // ****************
    typedef enum logic [2:0] {
        ST_SLEEP  = 3'b000,
        ST_INIT   = 3'b001,
        ST_SYNC   = 3'b010,
        ST_NORMAL = 3'b011,
        ST_BUSOFF = 3'b100
    } mode_t;

    typedef struct packed {
        logic [1:0] req;
        logic [1:0] done;
        logic [1:0] ok;
    } tx_evt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

/* can_bus_node.sv */
`timescale 1ns/10ps
// ****************
// frame source on the bus side
// ****************
module can_bus_node (
    // clock and start
    input  wire logic clk_i,
    input  wire logic go_i,
    // receive side seen by the block
    output logic      rx_o,
    output logic      act_o,
    output logic      sof_o
);
    int n = 0;
    initial begin
        rx_o = 1'b1;
        act_o = 1'b0;
        sof_o = 1'b0;
    end
    // six bit times, second, fourth and sixth dominant, recessive when idle
    always @(posedge clk_i) begin
        sof_o <= go_i && !act_o;
        if (go_i && !act_o) begin
            act_o <= 1'b1;
            n <= 600;
        end else if (n > 1) begin
            n <= n - 1;
        end else begin
            n <= 0;
            act_o <= 1'b0;
        end
        rx_o <= (n == 0) || ((n / 100) % 2 == 1);
    end
endmodule

/* can_mode_ctrl_properties.sv */
`timescale 1ns/10ps
module can_mode_ctrl_properties
    import can_mode_pkg::*;
(
    // clock and reset
    input wire logic       SYS_CLK_I,
    input wire logic       SRST_I,
    // watched ports
    input wire reg_req_t   REG_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       CAN_RX_I,
    input wire logic       RX_ACTIVE_I,
    input wire logic       TX_ACTIVE_I,
    input wire logic       SOF_DET_I,
    input wire logic [1:0] TX_PEND_I,
    input wire logic       RX_STORE_I,
    input wire logic       SLEEP_MODE_O,
    input wire logic       INIT_MODE_O,
    input wire logic       BUS_ON_O,
    input wire logic       NO_RETRANSMIT_O,
    input wire logic       RX_OVERWRITE_O,
    input wire logic       RX_DISCARD_O
);
    // ****************
    // shadow of policy bits, queue fill and recessive run
    // ****************
    logic       aw_reg;
    logic       lk_reg;
    logic [1:0] qn_reg;
    int         rc_reg;
    wire cw = REG_I.wr && REG_I.addr == OFS_MASTER_CONTROL;
    wire rs = REG_I.rd && REG_I.addr == OFS_MASTER_STATUS;
    wire rl = REG_I.wr && REG_I.addr == OFS_RX_QUEUE && REG_I.wdata[B_RELEASE] && qn_reg != 2'h0;
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            aw_reg <= 1'b0;
            lk_reg <= 1'b0;
        end else if (cw) begin
            aw_reg <= REG_I.wdata[B_AUTO_WAKEUP];
            lk_reg <= REG_I.wdata[B_RX_LOCK];
        end
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) qn_reg <= 2'h0;
        else if (RX_STORE_I && !rl && qn_reg != QUEUE_DEPTH) qn_reg <= qn_reg + 2'h1;
        else if (rl && !RX_STORE_I) qn_reg <= qn_reg - 2'h1;
    end
    always_ff @(posedge SYS_CLK_I) rc_reg <= (SRST_I || !CAN_RX_I) ? 0 : rc_reg + 1;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);
    a_status_live: assert property (rs |=> RDATA_O[7:4] ==
        {2'b00, $past(RX_ACTIVE_I), $past(TX_ACTIVE_I)}) else $error("activity bits wrong");
    a_ack_bits: assert property (rs |=> RDATA_O[1:0] ==
        {$past(SLEEP_MODE_O), $past(INIT_MODE_O)}) else $error("ack bits wrong");
    a_low_single: assert property (REG_I.rd && REG_I.addr == OFS_TX_PRIORITY && TX_PEND_I != 2'b11
        |=> RDATA_O[6:5] == 2'b00 && RDATA_O[3:2] == ~$past(TX_PEND_I)) else $error("low flags wrong");
    a_init_entry: assert property ($rose(INIT_MODE_O) && $past(BUS_ON_O)
        |-> !$past(RX_ACTIVE_I) && !$past(TX_ACTIVE_I)) else $error("init entered mid frame");
    a_sleep_entry: assert property ($rose(SLEEP_MODE_O) && $past(BUS_ON_O)
        |-> !$past(RX_ACTIVE_I) && !$past(TX_ACTIVE_I)) else $error("sleep entered mid frame");
    a_sync_wait: assert property ($rose(BUS_ON_O) |-> rc_reg >= 10 * BIT_CYCLES)
        else $error("bus on without recessive run");
    a_wake_manual: assert property (SLEEP_MODE_O && !aw_reg && !REG_I.wr && !$past(REG_I.wr)
        && !$past(REG_I.wr, 2) |=> SLEEP_MODE_O) else $error("left sleep unasked");
    a_wake_auto: assert property (SLEEP_MODE_O && aw_reg && SOF_DET_I && !REG_I.wr
        |-> ##[1:2] !SLEEP_MODE_O) else $error("no wake on frame");
    a_retx_policy: assert property (cw |=> NO_RETRANSMIT_O == $past(REG_I.wdata[B_NO_RETRANSMIT]))
        else $error("retransmit policy wrong");
    a_rx_overflow: assert property (RX_STORE_I && qn_reg == QUEUE_DEPTH && !REG_I.wr
        |=> (lk_reg ? RX_DISCARD_O && !RX_OVERWRITE_O : RX_OVERWRITE_O && !RX_DISCARD_O))
        else $error("overflow policy wrong");
    c_bus_on: cover property ($rose(BUS_ON_O));
    c_discard: cover property (RX_DISCARD_O);
    c_init: cover property ($rose(INIT_MODE_O));
endmodule

/* tb_can_mode_ctrl.sv */
`timescale 1ns/10ps
module tb_can_mode_ctrl
    import can_mode_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, txa = 1'b0, wins = 1'b0, store = 1'b0, boe = 1'b0;
    logic rx, rxa, sof, sm, im, bo, nrt, nmb, stc, w, rcv;
    reg_req_t   req = '0;
    tx_evt_t    tev = '0;
    logic [7:0] rdata;
    logic [3:0] err = '0;
    logic [1:0] pend = '0, p;
    int         miscompares = 0, cmp_count = 0, cyc = 0, i;
    int         seed = 32'hA16260E4;
    logic [7:0] rv [7] = '{8'h02, 8'h02, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00};

    always #10 clk = ~clk;

    can_mode_ctrl i_can_mode_ctrl (
        .SYS_CLK_I(clk), .SRST_I(rst), .REG_I(req), .RDATA_O(rdata), .CAN_RX_I(rx),
        .RX_ACTIVE_I(rxa), .TX_ACTIVE_I(txa), .SOF_DET_I(sof), .ERR_SET_I(err),
        .BUSOFF_ENTER_I(boe), .TX_EVT_I(tev), .TX_PEND_I(pend), .MB0_ID_WINS_I(wins),
        .RX_STORE_I(store), .SLEEP_MODE_O(sm), .INIT_MODE_O(im), .BUS_ON_O(bo),
        .BUSOFF_RECOVER_O(rcv), .NO_RETRANSMIT_O(nrt), .NEXT_TX_MB_O(nmb),
        .RX_OVERWRITE_O(), .RX_DISCARD_O(), .STATUS_CHANGE_O(stc));
    can_bus_node i_can_bus_node (.clk_i(clk), .go_i(go), .rx_o(rx), .act_o(rxa), .sof_o(sof));

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkf(string nm, logic e, logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 chk("rdata", e, rdata);
    endtask
    task automatic evt(tx_evt_t v);
        @(posedge clk) tev <= v;
        @(posedge clk) tev <= '0;
    endtask
    task automatic ep(logic [3:0] v);
        @(posedge clk) err <= v;
        @(posedge clk) err <= '0;
    endtask
    task automatic stq();
        @(posedge clk) store <= 1'b1;
        @(posedge clk) store <= 1'b0;
    endtask
    task automatic frm(bit open);
        int n;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (2) @(posedge clk);
        for (n = 0; n < 700 && !open && rxa; n++) @(posedge clk);
    endtask
    task automatic wt(ref logic f, input int lim, output int n);
        for (n = 0; n < lim && f !== 1'b1; n++) @(posedge clk);
    endtask
    // lowest flags, free flags and code for one id-ordered pending set
    function automatic logic [7:0] pr(logic [1:0] q, logic win);
        if (q == 2'b11) return win ? 8'h41 : 8'h20;
        return {4'h0, ~q, 1'b0, q[0]};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) rd(i[7:0], rv[i]);
        wr(8'h03, 8'hFF);
        wr(8'h01, 8'hF0);
        rd(8'h03, 8'h0C);
        rd(8'h01, 8'h02);
        $display("reset test done");
        wr(8'h05, 8'h80);
        frm(1'b0);
        chkf("sleep", 1'b1, sm);
        rd(8'h01, 8'h0A);
        chkf("change", 1'b1, stc);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h0A);
        wr(8'h01, 8'h08);
        rd(8'h01, 8'h02);
        chkf("change", 1'b0, stc);
        wr(8'h00, 8'h22);
        frm(1'b0);
        chkf("sleep", 1'b0, sm);
        rd(8'h00, 8'h20);
        wt(bo, 1300, i);
        chkf("bus on", 1'b1, bo);
        wr(8'h01, 8'h08);
        $display("wake test done");
        frm(1'b1);
        wr(8'h00, 8'h31);
        repeat (20) @(posedge clk);
        chkf("init", 1'b0, im);
        chkf("no retry", 1'b1, nrt);
        wt(im, 700, i);
        rd(8'h01, 8'h01);
        frm(1'b1);
        wr(8'h00, 8'h20);
        wt(bo, 2000, i);
        chkf("sync wait", 1'b1, bo && i >= 10 * BIT_CYCLES);
        chkf("no retry", 1'b0, nrt);
        frm(1'b1);
        wr(8'h00, 8'h02);
        repeat (20) @(posedge clk);
        chkf("sleep", 1'b0, sm);
        wt(sm, 700, i);
        rd(8'h01, 8'h02);
        wr(8'h00, 8'h00);
        repeat (2) @(posedge clk);
        rd(8'h01, 8'h00);
        $display("mode test done");
        evt('{2'b00, 2'b01, 2'b01});
        rd(8'h02, 8'h11);
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h11);
        evt('{2'b01, 2'b00, 2'b00});
        rd(8'h02, 8'h01);
        evt('{2'b00, 2'b10, 2'b10});
        rd(8'h02, 8'h23);
        wr(8'h02, 8'h02);
        rd(8'h02, 8'h01);
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'h00);
        repeat (8) begin
            p = 2'($random(seed));
            w = 1'($random(seed));
            @(posedge clk);
            pend <= p;
            wins <= w;
            rd(8'h03, pr(p, w));
        end
        wr(8'h00, 8'h04);
        wins <= 1'b0;
        evt('{2'b01, 2'b00, 2'b00});
        evt('{2'b10, 2'b00, 2'b00});
        pend <= 2'b11;
        rd(8'h03, 8'h41);
        chkf("next mb", 1'b0, nmb);
        wins <= 1'b1;
        evt('{2'b01, 2'b00, 2'b00});
        rd(8'h03, 8'h20);
        chkf("next mb", 1'b1, nmb);
        $display("transmit test done");
        repeat (3) stq();
        rd(8'h04, 8'h0B);
        stq();
        rd(8'h04, 8'h1B);
        wr(8'h04, 8'h20);
        rd(8'h04, 8'h12);
        wr(8'h00, 8'h08);
        repeat (2) stq();
        rd(8'h04, 8'h1B);
        wr(8'h05, 8'h41);
        txa <= 1'b1;
        ep(4'h1);
        rd(8'h01, 8'h14);
        chkf("change", 1'b1, stc);
        wr(8'h01, 8'h04);
        ep(4'h2);
        rd(8'h01, 8'h10);
        wt(bo, 1300, i);
        boe <= 1'b1;
        @(posedge clk) boe <= 1'b0;
        @(posedge clk) #1 chkf("bus off", 1'b0, bo);
        wr(8'h00, 8'h09);
        @(posedge clk) #1 chkf("recover", 1'b1, rcv);
        chkf("init", 1'b1, im);
        $display("queue and error test done");
        finish_test();
    end
endmodule

bind can_mode_ctrl can_mode_ctrl_properties i_can_mode_ctrl_properties (.*);
